//--- cdel_logger.sv
// data ram error logger with apb register access
`timescale 1ns/100ps
`default_nettype none

// Contract
// - capture all registers while nothing recorded
// - hold fixable capture; reload only on fatal
// - fatal capture sets lock bit zero
// - fatal while locked sets lost bit four
// - only status writable; clearing re-arms capture; interrupt enable and clear registers also take writes
// - fixable error sets bit one, loads registers
// - fatal error sets bit two, loads, locks
// - address fault sets bit three, loads, locks
// - lock always comes with fatal or fault
// - hardware sets flags; software writes one clears
// - operation code in bits 11:8, read-only
// - codes 0111, 0011, 0100 for reads, writeback
// - code 0010 for partial write merge
// - full writes and fills never log errors
// - index held; replaced only by fatal
// - index read-only, locked by lock flag
// - index in bits 16:3, 20:17 undefined
// - syndrome captured under same lock rules
module cdel_logger #(
   parameter int IDX_W = 14,
   parameter int SYN_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ecc_fixable,
   input wire logic ecc_fatal,
   input wire logic ecc_bad_addr,
   input wire logic [3:0] data_op_code,
   input wire logic [IDX_W-1:0] ecc_index,
   input wire logic [SYN_W-1:0] ecc_syndrome,
   output logic irq
);

   // address match used by read mux and write decode
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
      addr_is = (a == ofs);
   endfunction : addr_is

   // error flags and captured contents
   logic lock_reg, lock_next;
   logic fixable_error_flag, fixable_next;
   logic fatal_error_flag, fatal_next;
   logic bad_addr_reg, bad_addr_next;
   logic lost_reg, lost_next;
   logic [3:0] op_reg, op_next;
   logic [IDX_W-1:0] idx_reg, idx_next;
   logic [SYN_W-1:0] syn_reg, syn_next;
   // interrupt state
   logic [cdel_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
   logic [cdel_pkg::IRQ_W-1:0] irq_en_reg, irq_en_next;
   logic irq_reg, irq_next;
   // bus answer state
   logic [31:0] rdata_reg, rdata_next;
   logic ready_reg, ready_next;
   logic err_reg, err_next;

   // decoded events
   logic fatal_evt;
   logic load_evt;
   logic lost_evt;
   logic wr_fire;
   logic wr_status;
   logic [31:0] status_word;
   logic [31:0] index_word;

   // any uncorrectable kind, address fault counts too
   assign fatal_evt = ecc_fatal | ecc_bad_addr;
   // capture only when unlocked; fixable only when nothing held
   assign load_evt = !lock_reg &&
      (fatal_evt || (ecc_fixable && !fixable_error_flag));
   assign lost_evt = lock_reg && fatal_evt;
   // write lands on the completing access edge
   assign wr_fire = psel && penable && ready_reg && pwrite;
   // status is the only error register that takes writes
   assign wr_status = wr_fire && addr_is(paddr, cdel_pkg::OFS_STATUS);

   // status word as software sees it, op field read-only
   always_comb
   begin
      status_word = cdel_pkg::WORD_RST;
      status_word[cdel_pkg::BIT_LOCK] = lock_reg;
      status_word[cdel_pkg::BIT_FIXABLE] = fixable_error_flag;
      status_word[cdel_pkg::BIT_FATAL] = fatal_error_flag;
      status_word[cdel_pkg::BIT_BAD_ADDR] = bad_addr_reg;
      status_word[cdel_pkg::BIT_LOST] = lost_reg;
      status_word[cdel_pkg::OP_LSB +: 4] = op_reg;
   end

   // index sits at bits 16:3; upper undefined bits read zero
   always_comb
   begin
      index_word = cdel_pkg::WORD_RST;
      index_word[cdel_pkg::IDX_LSB +: IDX_W] = idx_reg;
   end

   // next values of flags and captured contents
   always_comb
   begin
      lock_next = lock_reg;
      fixable_next = fixable_error_flag;
      fatal_next = fatal_error_flag;
      bad_addr_next = bad_addr_reg;
      lost_next = lost_reg;
      op_next = op_reg;
      idx_next = idx_reg;
      syn_next = syn_reg;
      // software clears first so a same-cycle set wins
      if (wr_status)
      begin
         if (pwdata[cdel_pkg::BIT_LOCK])
            lock_next = 1'b0;
         if (pwdata[cdel_pkg::BIT_FIXABLE])
            fixable_next = 1'b0;
         if (pwdata[cdel_pkg::BIT_FATAL])
            fatal_next = 1'b0;
         if (pwdata[cdel_pkg::BIT_BAD_ADDR])
            bad_addr_next = 1'b0;
         if (pwdata[cdel_pkg::BIT_LOST])
            lost_next = 1'b0;
      end
      // capture path; op code passed through as the sequencer gives it
      if (load_evt)
      begin
         op_next = data_op_code;
         idx_next = ecc_index;
         syn_next = ecc_syndrome;
         if (fatal_evt)
         begin
            lock_next = 1'b1;
            // fault and fatal are exclusive; fault takes precedence
            if (ecc_bad_addr)
               bad_addr_next = 1'b1;
            else
               fatal_next = 1'b1;
         end
         else
         begin
            fixable_next = 1'b1;
         end
      end
      // nothing else moves while locked
      if (lost_evt)
         lost_next = 1'b1;
   end

   // flag and capture registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // all flags cleared so capture is armed
         lock_reg <= 1'b0;
         fixable_error_flag <= 1'b0;
         fatal_error_flag <= 1'b0;
         bad_addr_reg <= 1'b0;
         lost_reg <= 1'b0;
         op_reg <= 4'h0;
         idx_reg <= '0;
         syn_reg <= '0;
      end
      else
      begin
         lock_reg <= lock_next;
         fixable_error_flag <= fixable_next;
         fatal_error_flag <= fatal_next;
         bad_addr_reg <= bad_addr_next;
         lost_reg <= lost_next;
         op_reg <= op_next;
         idx_reg <= idx_next;
         syn_reg <= syn_next;
      end
   end

   // sticky interrupt status, enable, level output
   always_comb
   begin
      logic [cdel_pkg::IRQ_W-1:0] evt;
      logic [cdel_pkg::IRQ_W-1:0] clr;
      evt = '0;
      clr = '0;
      evt[cdel_pkg::IRQ_FIXABLE] = load_evt && !fatal_evt;
      evt[cdel_pkg::IRQ_FATAL] = load_evt && fatal_evt;
      evt[cdel_pkg::IRQ_LOST] = lost_evt;
      if (wr_fire && addr_is(paddr, cdel_pkg::OFS_IRQ_CLEAR))
         clr = pwdata[cdel_pkg::IRQ_W-1:0];
      irq_en_next = irq_en_reg;
      if (wr_fire && addr_is(paddr, cdel_pkg::OFS_IRQ_ENABLE))
         irq_en_next = pwdata[cdel_pkg::IRQ_W-1:0];
      // set beats clear bit by bit
      for (int i = 0; i < cdel_pkg::IRQ_W; i++)
         irq_stat_next[i] = evt[i] | (irq_stat_reg[i] & ~clr[i]);
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // interrupt registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= '0;
         irq_en_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_stat_reg <= irq_stat_next;
         irq_en_reg <= irq_en_next;
         irq_reg <= irq_next;
      end
   end

   // apb answer: ready and data fixed in the setup cycle
   always_comb
   begin
      rdata_next = rdata_reg;
      ready_next = 1'b0;
      err_next = 1'b0;
      if (psel && !penable)
      begin
         ready_next = 1'b1;
         rdata_next = cdel_pkg::WORD_RST;
         // read data sampled at setup; an error landing in the
         // access cycle shows on the next read
         if (addr_is(paddr, cdel_pkg::OFS_STATUS))
            rdata_next = status_word;
         else if (addr_is(paddr, cdel_pkg::OFS_INDEX))
            rdata_next = index_word;
         else if (addr_is(paddr, cdel_pkg::OFS_SYNDROME))
            rdata_next[SYN_W-1:0] = syn_reg;
         else if (addr_is(paddr, cdel_pkg::OFS_IRQ_STATUS))
            rdata_next[cdel_pkg::IRQ_W-1:0] = irq_stat_reg;
         else if (addr_is(paddr, cdel_pkg::OFS_IRQ_ENABLE))
            rdata_next[cdel_pkg::IRQ_W-1:0] = irq_en_reg;
         else if (addr_is(paddr, cdel_pkg::OFS_IRQ_CLEAR))
            rdata_next = cdel_pkg::WORD_RST;
         else
            err_next = 1'b1; // unmapped address
      end
   end

   // apb answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_reg <= cdel_pkg::WORD_RST;
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
      end
      else
      begin
         rdata_reg <= rdata_next;
         ready_reg <= ready_next;
         err_reg <= err_next;
      end
   end

   assign prdata = rdata_reg;
   assign pready = ready_reg;
   assign pslverr = err_reg;
   assign irq = irq_reg;

   // checks on the logging behaviour
   sequence fatal_unlocked_s;
      fatal_evt && !lock_reg;
   endsequence

   sequence fixable_fresh_s;
      ecc_fixable && !fatal_evt && !lock_reg && !fixable_error_flag;
   endsequence

   property capture_fatal_p;
      @(posedge pclk) disable iff (!presetn)
      fatal_unlocked_s |=> lock_reg && idx_reg == $past(ecc_index)
         && syn_reg == $past(ecc_syndrome);
   endproperty

   fatal_locks_a: assert property (capture_fatal_p)
      else $error("fatal error not captured and locked");

   fixable_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      fixable_fresh_s |=> fixable_error_flag && !lock_reg
         && op_reg == $past(data_op_code))
      else $error("fixable error not captured");

   fixable_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      fixable_error_flag && !lock_reg && !fatal_evt |=> $stable(idx_reg)
         && $stable(syn_reg))
      else $error("held fixable capture overwritten");

   lost_set_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      lock_reg && fatal_evt |=> lost_reg && $stable(idx_reg)
         && $stable(op_reg) && $stable(syn_reg))
      else $error("lost flag missing or contents changed");

   lock_type_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(lock_reg) |-> ($past(ecc_bad_addr)
         ? (bad_addr_reg && !$rose(fatal_error_flag))
         : (fatal_error_flag && !$rose(bad_addr_reg))))
      else $error("lock without exactly one type flag");

   fault_kind_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ecc_bad_addr && !lock_reg |=> bad_addr_reg && lock_reg
         && !$rose(fatal_error_flag))
      else $error("address fault not logged");

   clear_one_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_status && !pwdata[cdel_pkg::BIT_LOST] && lost_reg |=> lost_reg)
      else $error("writing zero cleared a flag");

   rearm_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_status && pwdata[cdel_pkg::BIT_LOCK] && pwdata[cdel_pkg::BIT_FIXABLE]
         && !fatal_evt && !ecc_fixable |=> !lock_reg && !fixable_error_flag)
      else $error("capture not re-armed after clear");

   op_field_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && addr_is(paddr, cdel_pkg::OFS_STATUS)
         |=> prdata[11:8] == $past(op_reg))
      else $error("operation field misread");

   index_pos_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && addr_is(paddr, cdel_pkg::OFS_INDEX)
         |=> prdata[16:3] == $past(idx_reg) && prdata[2:0] == 3'h0)
      else $error("index misplaced in read word");

endmodule : cdel_logger

`default_nettype wire

//--- cdel_pkg.sv
// constants for the cache data error logger
package cdel_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_INDEX = 8'h04;
   localparam logic [7:0] OFS_SYNDROME = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
   // status field positions
   localparam int BIT_LOCK = 0;
   localparam int BIT_FIXABLE = 1;
   localparam int BIT_FATAL = 2;
   localparam int BIT_BAD_ADDR = 3;
   localparam int BIT_LOST = 4;
   localparam int OP_LSB = 8;
   localparam int IDX_LSB = 3;
   // data operation codes
   localparam logic [3:0] OP_DATA_STREAM = 4'h7;
   localparam logic [3:0] OP_INSTR_STREAM = 4'h3;
   localparam logic [3:0] OP_WRITEBACK = 4'h4;
   localparam logic [3:0] OP_PARTIAL_MERGE = 4'h2;
   // interrupt event positions
   localparam int IRQ_FIXABLE = 0;
   localparam int IRQ_FATAL = 1;
   localparam int IRQ_LOST = 2;
   localparam int IRQ_W = 3;
   // reset values
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage : cdel_pkg

//--- cdel_decoder_model.sv
// behavioural ecc decoder that reports data ram errors to the logger
`timescale 1ns/100ps
`default_nettype none
module cdel_decoder_model #(
   parameter int IDX_W = 14,
   parameter int SYN_W = 8
) (
   input wire logic pclk,
   output logic ecc_fixable,
   output logic ecc_fatal,
   output logic ecc_bad_addr,
   output logic [3:0] data_op_code,
   output logic [IDX_W-1:0] ecc_index,
   output logic [SYN_W-1:0] ecc_syndrome
);
   // quiet at time zero, nothing reported
   initial
   begin
      ecc_fixable = 1'b0;
      ecc_fatal = 1'b0;
      ecc_bad_addr = 1'b0;
      data_op_code = 4'h0;
      ecc_index = '0;
      ecc_syndrome = '0;
   end
   // one-cycle report; kind bit 0 fixable, bit 1 fatal, bit 2 bad address
   task fire(input logic [2:0] kind, input logic [3:0] op, input logic [IDX_W-1:0] idx,
      input logic [SYN_W-1:0] syn);
      @(posedge pclk);
      ecc_fixable <= kind[0];
      ecc_fatal <= kind[1];
      ecc_bad_addr <= kind[2];
      data_op_code <= op; // only lookups report, never full writes or fills
      ecc_index <= idx;
      ecc_syndrome <= syn;
      @(posedge pclk);
      // qualifiers are stale after the pulse, so show the inverse, not the old value
      ecc_fixable <= 1'b0;
      ecc_fatal <= 1'b0;
      ecc_bad_addr <= 1'b0;
      data_op_code <= ~op;
      ecc_index <= ~idx;
      ecc_syndrome <= ~syn;
   endtask : fire
endmodule : cdel_decoder_model
`default_nettype wire

//--- cdel_logger_tb.sv
// self-checking testbench of the data ram error logger
`timescale 1ns/100ps
`default_nettype none
`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module cdel_logger_tb;
   logic pclk = 1'b0; // 100 mhz bus clock
   logic presetn = 1'b0; // reset, active low
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ecc_fixable;
   logic ecc_fatal;
   logic ecc_bad_addr;
   logic [3:0] data_op_code;
   logic [13:0] ecc_index;
   logic [7:0] ecc_syndrome;
   logic irq;
   logic [31:0] rdat; // data of the last transfer
   logic rerr; // error answer of the last transfer
   int miscompares = 0;
   int compares = 0;
   int cycles = 0; // hang guard
   // clock
   always #5 pclk = ~pclk;
   cdel_logger uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ecc_fixable(ecc_fixable), .ecc_fatal(ecc_fatal),
      .ecc_bad_addr(ecc_bad_addr), .data_op_code(data_op_code), .ecc_index(ecc_index),
      .ecc_syndrome(ecc_syndrome), .irq(irq));
   cdel_decoder_model dec (.pclk(pclk), .ecc_fixable(ecc_fixable), .ecc_fatal(ecc_fatal),
      .ecc_bad_addr(ecc_bad_addr), .data_op_code(data_op_code), .ecc_index(ecc_index),
      .ecc_syndrome(ecc_syndrome));
   // verdict and end of run
   task results;
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   // whole run needs under two hundred cycles; far beyond that means a hang
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         miscompares++;
         results();
      end
   end
   // one apb transfer; request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // values read right after the edge are the ones sampled at it
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // read one register and compare it
   task expect_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `chk(nm, e, rdat)
   endtask : expect_rd
   // irq level after the last edge has landed
   task expect_irq(input logic e);
      @(negedge pclk);
      `chk("irq", e, irq)
   endtask : expect_irq
   // status word from operation code and flags
   function automatic logic [31:0] st(input logic [3:0] op, input logic [4:0] fl);
      st = (32'(op) << cdel_pkg::OP_LSB) | 32'(fl);
   endfunction : st
   // main sequence
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      expect_rd("status", cdel_pkg::OFS_STATUS, 32'h0000_0000);
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0000_0000);
      expect_rd("irq status", cdel_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
      apb(1'b1, cdel_pkg::OFS_IRQ_ENABLE, 32'h0000_0007);
      expect_rd("irq enable", cdel_pkg::OFS_IRQ_ENABLE, 32'h0000_0007);
      expect_rd("irq clear", cdel_pkg::OFS_IRQ_CLEAR, 32'h0000_0000);
      // first fixable error is captured, boundary index
      dec.fire(3'h1, cdel_pkg::OP_DATA_STREAM, 14'h3FFF, 8'hA5);
      expect_irq(1'b1);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h7, 5'h02));
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0001_FFF8);
      expect_rd("syndrome", cdel_pkg::OFS_SYNDROME, 32'h0000_00A5);
      // second fixable error is ignored
      dec.fire(3'h1, cdel_pkg::OP_INSTR_STREAM, 14'h0001, 8'h11);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h7, 5'h02));
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0001_FFF8);
      // fatal error reloads and locks
      dec.fire(3'h2, cdel_pkg::OP_INSTR_STREAM, 14'h0002, 8'h22);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h3, 5'h07));
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0000_0010);
      expect_rd("syndrome", cdel_pkg::OFS_SYNDROME, 32'h0000_0022);
      // fatal while locked only marks the loss
      dec.fire(3'h2, cdel_pkg::OP_WRITEBACK, 14'h0005, 8'h33);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h3, 5'h17));
      // capture registers refuse software writes
      apb(1'b1, cdel_pkg::OFS_INDEX, 32'hFFFF_FFFF);
      apb(1'b1, cdel_pkg::OFS_SYNDROME, 32'hFFFF_FFFF);
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0000_0010);
      expect_rd("syndrome", cdel_pkg::OFS_SYNDROME, 32'h0000_0022);
      // writing zero leaves flags, writing ones clears them
      apb(1'b1, cdel_pkg::OFS_STATUS, 32'h0000_0000);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h3, 5'h17));
      apb(1'b1, cdel_pkg::OFS_STATUS, 32'h0000_001F);
      apb(1'b0, cdel_pkg::OFS_STATUS, 32'h0000_0000);
      `chk("flags", 5'h00, rdat[4:0])
      // capture re-armed; partial write merge code
      dec.fire(3'h1, cdel_pkg::OP_PARTIAL_MERGE, 14'h0007, 8'h44);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h2, 5'h02));
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0000_0038);
      // address fault counts as fatal
      apb(1'b1, cdel_pkg::OFS_STATUS, 32'h0000_001F);
      dec.fire(3'h4, cdel_pkg::OP_WRITEBACK, 14'h0008, 8'h55);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h4, 5'h09));
      expect_rd("syndrome", cdel_pkg::OFS_SYNDROME, 32'h0000_0055);
      // interrupt clear, then masked event
      apb(1'b1, cdel_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
      expect_rd("irq status", cdel_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
      expect_irq(1'b0);
      apb(1'b1, cdel_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
      apb(1'b1, cdel_pkg::OFS_STATUS, 32'h0000_001F);
      dec.fire(3'h1, cdel_pkg::OP_DATA_STREAM, 14'h0009, 8'h66);
      expect_irq(1'b0);
      expect_rd("irq status", cdel_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      // unmapped address answers with an error and zero data
      expect_rd("unmapped", 8'h40, 32'h0000_0000);
      `chk("slave error", 1'b1, rerr)
      // fatal and address fault together log only the fault
      apb(1'b1, cdel_pkg::OFS_STATUS, 32'h0000_001F);
      dec.fire(3'h6, cdel_pkg::OP_DATA_STREAM, 14'h000A, 8'h77);
      expect_rd("status", cdel_pkg::OFS_STATUS, st(4'h7, 5'h09));
      expect_rd("index", cdel_pkg::OFS_INDEX, 32'h0000_0050);
      results();
   end
endmodule : cdel_logger_tb
`default_nettype wire
